// *** include/ep_ctrl_pkg.sv ***
// Package for the device endpoint control block: register map, fields, types.
// Assumes a 32-bit APB bus and a single pclk domain.
package ep_ctrl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;      // Role and soft connect
  localparam logic [7:0] OFS_SEL = 8'h04;       // Endpoint and direction select
  localparam logic [7:0] OFS_CFG = 8'h08;       // Selected endpoint configuration
  localparam logic [7:0] OFS_MAXPKT = 8'h0c;    // Selected endpoint max packet bytes
  localparam logic [7:0] OFS_STALL = 8'h10;     // Write 1 set stall, read state
  localparam logic [7:0] OFS_UNSTALL = 8'h14;   // Write 1 clear stall
  localparam logic [7:0] OFS_STATUS = 8'h18;    // Endpoint status, write 1 clear
  localparam logic [7:0] OFS_ACK = 8'h1c;       // Receive acknowledge
  localparam logic [7:0] OFS_COUNT = 8'h20;     // Received bytes held
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;  // Sticky events, write 1 clear
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;  // Interrupt enables

  // Field positions
  localparam int MODE_DEV_BIT = 0;     // Device role
  localparam int MODE_CONN_BIT = 1;    // Soft connect
  localparam int SEL_DIR_BIT = 8;      // 1 = IN direction
  localparam int CFG_TYPE_LSB = 0;     // Endpoint type, 2 bits
  localparam int CFG_DMA_LSB = 2;      // DMA access mode, 2 bits
  localparam int CFG_AUTOTX_BIT = 4;   // Auto transmit full packet
  localparam int CFG_AUTORQ_BIT = 5;   // Auto receive request
  localparam int CFG_AUTOCLR_BIT = 6;  // Auto packet ready clear
  localparam int ACK_LAST_BIT = 0;     // Last packet indication
  localparam int ST_RXRDY_BIT = 0;     // OUT packet ready
  localparam int ST_TXPEND_BIT = 1;    // IN packet pending
  localparam int ST_STALLSENT_BIT = 2; // Stall handshake sent
  localparam int ST_DATAEND_BIT = 3;   // Endpoint zero data end
  localparam int IRQ_RX_BIT = 0;       // Packet received
  localparam int IRQ_TX_BIT = 1;       // Packet sent
  localparam int IRQ_STALL_BIT = 2;    // Stall sent

  localparam int ST_W = 4;
  localparam int IRQ_W = 3;

  // Endpoint transfer types
  typedef enum logic [1:0] {
    endpoint_type_control = 2'b00,
    endpoint_type_isochronous = 2'b01,
    endpoint_type_bulk = 2'b10,
    endpoint_type_interrupt = 2'b11
  } ep_kind_type;

  // Per endpoint, per direction configuration
  typedef struct packed {
    ep_kind_type kind;
    logic [1:0] endpoint_dma_access_mode;
    logic auto_transmit_full_packet;
    logic auto_receive_request;
    logic auto_packet_ready_clear;
  } ep_cfg_type;

  // Link side event group from the packet engine
  typedef struct packed {
    logic rx_done;      // A packet landed in an OUT FIFO
    logic tx_done;      // An IN packet left
    logic stall_sent;   // A stall handshake was sent
  } link_evt_type;

endpackage : ep_ctrl_pkg

// *** core/usb_ep_ctrl.sv ***
// Device endpoint control: configuration, stall, status, auto modes, APB slave.
// Assumes an outside packet engine and FIFO that report byte writes and reads.
//
// Behaviour
// - Auto transmit when max packet written
// - Auto request once FIFO space allows, in device role only
// - Auto clear ready after FIFO drained
// - Else ready holds until software clears
// - Endpoint zero configuration is fixed
// - Endpoint holds type and max packet
// - Endpoint holds DMA access mode
// - Configuration read back matches last write beyond endpoint zero
// - Stall IN or OUT independently
// - Clear stall IN or OUT independently
// - Receive acknowledge, last flag on zero
// - Last flag ignored beyond endpoint zero
// - Clear exactly the marked status bits
// - Report received bytes held in FIFO
// - Mode switch selects device role
// - Soft connect attaches or detaches, in device role only
`timescale 1ns/1ps
module usb_ep_ctrl
  import ep_ctrl_pkg::*;
#(
  parameter int NUM_EP = 4,       // Endpoints including zero
  parameter int EPW = 2,          // Endpoint index width
  parameter int MAXW = 11,        // Max packet width
  parameter int CNTW = 12,        // FIFO byte count width
  parameter int FIFO_BYTES = 64,  // OUT FIFO size per endpoint
  parameter logic [MAXW-1:0] EP0_MAXPKT = 11'h040  // Fixed endpoint zero size
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // FIFO activity from the data path
  input wire logic in_byte_wr,
  input wire logic [EPW-1:0] in_byte_ep,
  input wire logic out_byte_rd,
  input wire logic [EPW-1:0] out_byte_ep,
  input wire logic out_byte_wr,
  input wire logic [EPW-1:0] out_wr_ep,
  // Packet engine events
  input wire link_evt_type link_evt,
  input wire logic [EPW-1:0] link_ep,
  // Controls to the packet engine
  output logic [NUM_EP-1:0] tx_start,
  output logic [NUM_EP-1:0] rx_request,
  output logic [NUM_EP-1:0] rx_ack,
  output logic ep0_data_end,
  output logic [NUM_EP-1:0] stall_in,
  output logic [NUM_EP-1:0] stall_out,
  output logic device_role,
  output logic soft_connect,
  output logic irq
);

  // Whole module state
  typedef struct packed {
    logic dev;
    logic conn;
    logic [EPW-1:0] sel_ep;
    logic sel_in;
    ep_cfg_type [NUM_EP-1:0] cfg_in;
    ep_cfg_type [NUM_EP-1:0] cfg_out;
    logic [NUM_EP-1:0][MAXW-1:0] max_in;
    logic [NUM_EP-1:0][MAXW-1:0] max_out;
    logic [NUM_EP-1:0][CNTW-1:0] wr_cnt;   // IN bytes written since last send
    logic [NUM_EP-1:0][CNTW-1:0] rx_cnt;   // OUT bytes held
    logic [NUM_EP-1:0] stl_in;
    logic [NUM_EP-1:0] stl_out;
    logic [NUM_EP-1:0][ST_W-1:0] st_in;
    logic [NUM_EP-1:0][ST_W-1:0] st_out;
    logic [NUM_EP-1:0] tx_go;
    logic [NUM_EP-1:0] rq;
    logic [NUM_EP-1:0] ack;
    logic dend;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  // Effective max packet, fixed on endpoint zero
  function automatic logic [MAXW-1:0] eff_max(input logic [EPW-1:0] ep,
                                              input logic [MAXW-1:0] v);
    eff_max = (ep == '0) ? EP0_MAXPKT : v;
  endfunction : eff_max

  // Configuration packed into its register layout
  function automatic logic [31:0] cfg_word(input ep_cfg_type c);
    cfg_word = '0;
    cfg_word[CFG_TYPE_LSB +: 2] = c.kind;
    cfg_word[CFG_DMA_LSB +: 2] = c.endpoint_dma_access_mode;
    cfg_word[CFG_AUTOTX_BIT] = c.auto_transmit_full_packet;
    cfg_word[CFG_AUTORQ_BIT] = c.auto_receive_request;
    cfg_word[CFG_AUTOCLR_BIT] = c.auto_packet_ready_clear;
  endfunction : cfg_word

  // Register word unpacked into a configuration, same layout as cfg_word
  function automatic ep_cfg_type cfg_from(input logic [31:0] w);
    cfg_from.kind = ep_kind_type'(w[CFG_TYPE_LSB +: 2]);
    cfg_from.endpoint_dma_access_mode = w[CFG_DMA_LSB +: 2];
    cfg_from.auto_transmit_full_packet = w[CFG_AUTOTX_BIT];
    cfg_from.auto_receive_request = w[CFG_AUTORQ_BIT];
    cfg_from.auto_packet_ready_clear = w[CFG_AUTOCLR_BIT];
  endfunction : cfg_from

  logic acc;
  logic wr;
  logic [EPW-1:0] se;
  logic [31:0] rd;
  logic [CNTW-1:0] free_b;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign se = st_ff.sel_ep;

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_go = '0;
    nxt_st.ack = '0;
    nxt_st.dend = 1'b0;
    rd = '0;
    free_b = '0;
    // FIFO byte counting per endpoint
    for (int i = 0; i < NUM_EP; i++) begin
      if (in_byte_wr && in_byte_ep == EPW'(i)) begin
        nxt_st.wr_cnt[i] = st_ff.wr_cnt[i] + 1'b1;
      end
      if (out_byte_wr && out_wr_ep == EPW'(i)) begin
        nxt_st.rx_cnt[i] = nxt_st.rx_cnt[i] + 1'b1;
      end
      if (out_byte_rd && out_byte_ep == EPW'(i) && st_ff.rx_cnt[i] != '0) begin
        nxt_st.rx_cnt[i] = nxt_st.rx_cnt[i] - 1'b1;
      end
    end
    // Automatic behaviour per endpoint
    for (int i = 0; i < NUM_EP; i++) begin
      // Send once a full packet is loaded
      if (st_ff.cfg_in[i].auto_transmit_full_packet && !st_ff.st_in[i][ST_TXPEND_BIT] &&
          nxt_st.wr_cnt[i] >= CNTW'(eff_max(EPW'(i), st_ff.max_in[i]))) begin
        nxt_st.tx_go[i] = 1'b1;
        nxt_st.wr_cnt[i] = '0;
        nxt_st.st_in[i][ST_TXPEND_BIT] = 1'b1;
      end
      // Request more when room for a whole packet
      free_b = CNTW'(FIFO_BYTES) - nxt_st.rx_cnt[i];
      nxt_st.rq[i] = st_ff.cfg_out[i].auto_receive_request && st_ff.dev &&
                     free_b >= CNTW'(eff_max(EPW'(i), st_ff.max_out[i]));
      // Drained packet clears ready by itself
      if (st_ff.cfg_out[i].auto_packet_ready_clear && st_ff.st_out[i][ST_RXRDY_BIT] &&
          out_byte_rd && out_byte_ep == EPW'(i) && st_ff.rx_cnt[i] == CNTW'(1)) begin
        nxt_st.st_out[i][ST_RXRDY_BIT] = 1'b0;
      end
    end
    // Software register writes
    if (wr) begin
      unique case (paddr)
        OFS_MODE: begin
          nxt_st.dev = pwdata[MODE_DEV_BIT];
          nxt_st.conn = pwdata[MODE_CONN_BIT];
        end
        OFS_SEL: begin
          nxt_st.sel_ep = pwdata[EPW-1:0];
          nxt_st.sel_in = pwdata[SEL_DIR_BIT];
        end
        OFS_CFG: begin
          // Endpoint zero ignores configuration writes
          if (se != '0) begin
            if (st_ff.sel_in) begin
              nxt_st.cfg_in[se] = cfg_from(pwdata);
            end else begin
              nxt_st.cfg_out[se] = cfg_from(pwdata);
            end
          end
        end
        OFS_MAXPKT: begin
          if (se != '0) begin
            if (st_ff.sel_in) begin
              nxt_st.max_in[se] = pwdata[MAXW-1:0];
            end else begin
              nxt_st.max_out[se] = pwdata[MAXW-1:0];
            end
          end
        end
        OFS_STALL: begin
          nxt_st.stl_in = st_ff.stl_in | pwdata[NUM_EP-1:0];
          nxt_st.stl_out = st_ff.stl_out | pwdata[16 +: NUM_EP];
        end
        OFS_UNSTALL: begin
          nxt_st.stl_in = st_ff.stl_in & ~pwdata[NUM_EP-1:0];
          nxt_st.stl_out = st_ff.stl_out & ~pwdata[16 +: NUM_EP];
        end
        OFS_STATUS: begin
          // Only marked bits clear
          if (st_ff.sel_in) begin
            nxt_st.st_in[se] = nxt_st.st_in[se] & ~pwdata[ST_W-1:0];
          end else begin
            nxt_st.st_out[se] = nxt_st.st_out[se] & ~pwdata[ST_W-1:0];
          end
        end
        OFS_ACK: begin
          nxt_st.ack[se] = 1'b1;
          nxt_st.st_out[se][ST_RXRDY_BIT] = 1'b0;
          nxt_st.dend = (se == '0) && pwdata[ACK_LAST_BIT];
        end
        OFS_IRQ_STAT: nxt_st.irq_st = st_ff.irq_st & ~pwdata[IRQ_W-1:0];
        OFS_IRQ_MASK: nxt_st.irq_mask = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Link events update status last; they win over a same-cycle write or auto update
    if (link_evt.rx_done) begin
      nxt_st.st_out[link_ep][ST_RXRDY_BIT] = 1'b1;
      nxt_st.irq_st[IRQ_RX_BIT] = 1'b1;
    end
    if (link_evt.tx_done) begin
      nxt_st.st_in[link_ep][ST_TXPEND_BIT] = 1'b0;
      nxt_st.irq_st[IRQ_TX_BIT] = 1'b1;
    end
    if (link_evt.stall_sent) begin
      nxt_st.st_in[link_ep][ST_STALLSENT_BIT] = st_ff.stl_in[link_ep];
      nxt_st.st_out[link_ep][ST_STALLSENT_BIT] = st_ff.stl_out[link_ep];
      nxt_st.irq_st[IRQ_STALL_BIT] = 1'b1;
    end
    // Read mux
    unique case (paddr)
      OFS_MODE: begin
        rd[MODE_DEV_BIT] = st_ff.dev;
        rd[MODE_CONN_BIT] = st_ff.conn;
      end
      OFS_SEL: begin
        rd[EPW-1:0] = st_ff.sel_ep;
        rd[SEL_DIR_BIT] = st_ff.sel_in;
      end
      OFS_CFG: rd = st_ff.sel_in ? cfg_word(st_ff.cfg_in[se]) : cfg_word(st_ff.cfg_out[se]);
      OFS_MAXPKT: rd[MAXW-1:0] = st_ff.sel_in ? eff_max(se, st_ff.max_in[se]) :
                                 eff_max(se, st_ff.max_out[se]);
      OFS_STALL: begin
        rd[NUM_EP-1:0] = st_ff.stl_in;
        rd[16 +: NUM_EP] = st_ff.stl_out;
      end
      OFS_STATUS: rd[ST_W-1:0] = st_ff.sel_in ? st_ff.st_in[se] : st_ff.st_out[se];
      OFS_COUNT: rd[CNTW-1:0] = st_ff.rx_cnt[se];
      OFS_IRQ_STAT: rd[IRQ_W-1:0] = st_ff.irq_st;
      OFS_IRQ_MASK: rd[IRQ_W-1:0] = st_ff.irq_mask;
      default: rd = '0;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = rd;
  assign tx_start = st_ff.tx_go;
  assign rx_request = st_ff.rq;
  assign rx_ack = st_ff.ack;
  assign ep0_data_end = st_ff.dend;
  assign stall_in = st_ff.stl_in;
  assign stall_out = st_ff.stl_out;
  assign device_role = st_ff.dev;
  assign soft_connect = st_ff.conn && st_ff.dev;
  assign irq = |(st_ff.irq_st & st_ff.irq_mask);

endmodule : usb_ep_ctrl

// *** sim/usb_ep_ctrl_properties.sv ***
// Port-level checker for the endpoint control block.
// Assumes one pclk domain and zero-wait APB; bound to every usb_ep_ctrl.
`timescale 1ns/1ps
module usb_ep_ctrl_properties
  import ep_ctrl_pkg::*;
#(
  parameter int NUM_EP = 4  // Endpoints including zero
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_EP-1:0] tx_start,
  input wire logic [NUM_EP-1:0] rx_ack,
  input wire logic ep0_data_end,
  input wire logic [NUM_EP-1:0] stall_in,
  input wire logic [NUM_EP-1:0] stall_out,
  input wire logic device_role,
  input wire logic soft_connect
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write in this cycle
  wire logic wr = psel && penable && pwrite && pready;
  // Role bit of the last bus word, to compare with the role output
  logic role_q;
  always_ff @(posedge pclk) begin
    role_q <= pwdata[MODE_DEV_BIT];
  end
  AST_NO_WAIT: assert property (psel && penable |-> pready && !pslverr)
    else $error("access phase not answered at once");
  AST_STALL_IN: assert property (wr && paddr == OFS_STALL && pwdata[1] |=> stall_in[1])
    else $error("IN stall not set");
  AST_STALL_KEEP: assert property (wr && paddr == OFS_STALL && pwdata[31:16] == 16'h0000
    |=> $stable(stall_out))
    else $error("OUT stall moved by IN stall write");
  AST_UNSTALL_IN: assert property (wr && paddr == OFS_UNSTALL && pwdata[1] |=> !stall_in[1])
    else $error("IN stall not cleared");
  AST_UNSTALL_KEEP: assert property (wr && paddr == OFS_UNSTALL && pwdata[31:16] == 16'h0000
    |=> $stable(stall_out))
    else $error("OUT stall moved by IN clear");
  AST_ROLE: assert property (wr && paddr == OFS_MODE |=> device_role == role_q)
    else $error("role output differs from written bit");
  AST_CONN: assert property (soft_connect |-> device_role)
    else $error("connected without device role");
  AST_LAST_EP0: assert property (ep0_data_end |-> rx_ack[0])
    else $error("data end without endpoint zero ack");
  AST_TX_ONCE: assert property (tx_start[1] |=> !tx_start[1] [*3])
    else $error("second start while packet pending");
  // Main scenarios reached
  cover property (tx_start[1]);
  cover property (ep0_data_end);
  cover property (soft_connect);
endmodule : usb_ep_ctrl_properties

bind usb_ep_ctrl usb_ep_ctrl_properties #(.NUM_EP(NUM_EP)) u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .tx_start, .rx_ack, .ep0_data_end,
  .stall_in, .stall_out, .device_role, .soft_connect);

// *** sim/usb_host_model.sv ***
// Far-side stand-in: packet engine events and FIFO byte strobes.
// Assumes burst() is entered just after a clock edge.
`timescale 1ns/1ps
module usb_host_model
  import ep_ctrl_pkg::*;
(
  input wire logic pclk,
  output logic in_byte_wr,
  output logic [1:0] in_byte_ep,
  output logic out_byte_wr,
  output logic [1:0] out_wr_ep,
  output logic out_byte_rd,
  output logic [1:0] out_byte_ep,
  output link_evt_type link_evt,
  output logic [1:0] link_ep
);
  // Quiet at time zero
  initial begin
    {in_byte_wr, out_byte_wr, out_byte_rd, link_evt} = '0;
    {in_byte_ep, out_wr_ep, out_byte_ep, link_ep} = '0;
  end
  // Strobe k (in wr, out wr, out rd, rx, tx, stall) for n cycles on endpoint ep
  task automatic burst(input int k, input logic [1:0] ep, input int n);
    repeat (n) begin
      @(posedge pclk);
      {in_byte_wr, out_byte_wr, out_byte_rd, link_evt} <= 6'h20 >> k;
      {in_byte_ep, out_wr_ep, out_byte_ep, link_ep} <= {4{ep}};
    end
    @(posedge pclk);
    {in_byte_wr, out_byte_wr, out_byte_rd, link_evt} <= '0;
    // Released selects show a changed value, never the stale one
    {in_byte_ep, out_wr_ep, out_byte_ep, link_ep} <= {4{~ep}};
  endtask : burst
endmodule : usb_host_model

// *** sim/usb_device_endpoint_control_tb.sv ***
// Self-checking bench: APB register sequences plus far-side byte traffic.
// Assumes default parameters (4 endpoints, 64-byte OUT FIFO, endpoint zero 64 bytes).
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module usb_device_endpoint_control_tb;
  import ep_ctrl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic ep0_data_end, device_role, soft_connect, in_byte_wr, out_byte_rd, out_byte_wr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] in_byte_ep, out_byte_ep, out_wr_ep, link_ep;
  link_evt_type link_evt;
  logic [3:0] tx_start, rx_request, rx_ack, stall_in, stall_out;
  int err_count = 0, checks = 0, cyc = 0, tx_n = 0, end_n = 0, ack_n = 0;
  usb_ep_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .in_byte_wr, .in_byte_ep, .out_byte_rd, .out_byte_ep, .out_byte_wr, .out_wr_ep,
    .link_evt, .link_ep, .tx_start, .rx_request, .rx_ack, .ep0_data_end, .stall_in, .stall_out,
    .device_role, .soft_connect, .irq);
  usb_host_model host (.pclk, .in_byte_wr, .in_byte_ep, .out_byte_wr, .out_wr_ep, .out_byte_rd,
    .out_byte_ep, .link_evt, .link_ep);
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // Pulse counters and hang guard
  always @(posedge pclk) begin
    cyc++;
    tx_n += tx_start[1];
    end_n += ep0_data_end;
    ack_n += rx_ack[1];
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // One APB transfer; read data taken at the edge that sees pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd
  // Let registered outputs settle
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0);
    wr(OFS_MODE, 32'h2);
    tick(1);
    `CHK(soft_connect, 1'b0)
    wr(OFS_MODE, 32'h3);
    tick(1);
    `CHK({device_role, soft_connect}, 2'b11)
    // Every type and DMA mode, both directions, then read all back
    for (int i = 0; i < 6; i++) begin
      wr(OFS_SEL, (i / 2 + 1) | (i % 2) << 8);
      wr(OFS_CFG, (i % 4) | ((i + 1) % 4) << 2);
      wr(OFS_MAXPKT, 8 + i);
    end
    for (int i = 0; i < 6; i++) begin
      wr(OFS_SEL, (i / 2 + 1) | (i % 2) << 8);
      rd(OFS_CFG, (i % 4) | ((i + 1) % 4) << 2);
      rd(OFS_MAXPKT, 8 + i);
    end
    wr(OFS_SEL, 32'h0);
    wr(OFS_CFG, 32'h3);
    wr(OFS_MAXPKT, 32'h8);
    rd(OFS_CFG, 32'h0);
    rd(OFS_MAXPKT, 32'h40);
    wr(OFS_STALL, 32'h2);
    tick(1);
    `CHK({stall_in, stall_out}, 8'h20)
    wr(OFS_STALL, 32'h2_0000);
    wr(OFS_UNSTALL, 32'h2);
    tick(1);
    `CHK({stall_in, stall_out}, 8'h02)
    rd(OFS_STALL, 32'h2_0000);
    // Auto transmit on endpoint 1 IN at exactly eight bytes
    wr(OFS_SEL, 32'h101);
    wr(OFS_CFG, 32'h10);
    wr(OFS_MAXPKT, 32'h8);
    host.burst(0, 2'd1, 7);
    tick(2);
    `CHK(tx_n, 0)
    host.burst(0, 2'd1, 1);
    tick(2);
    `CHK(tx_n, 1)
    // Endpoint 2 OUT with auto request and auto clear
    wr(OFS_SEL, 32'h2);
    wr(OFS_CFG, 32'h60);
    wr(OFS_MAXPKT, 32'h8);
    tick(2);
    `CHK(rx_request[2], 1'b1)
    host.burst(1, 2'd2, 60);
    host.burst(3, 2'd2, 1);
    tick(2);
    `CHK(rx_request[2], 1'b0)
    rd(OFS_COUNT, 32'd60);
    rd(OFS_STATUS, 32'h1);
    host.burst(2, 2'd2, 4);
    tick(2);
    `CHK(rx_request[2], 1'b1)
    host.burst(2, 2'd2, 56);
    rd(OFS_STATUS, 32'h0);
    // Endpoint 3 OUT without auto clear
    wr(OFS_SEL, 32'h3);
    host.burst(1, 2'd3, 4);
    host.burst(3, 2'd3, 1);
    host.burst(2, 2'd3, 4);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'he);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    rd(OFS_STATUS, 32'h0);
    // Acknowledge with last flag on endpoint zero, then endpoint 1
    wr(OFS_SEL, 32'h0);
    wr(OFS_ACK, 32'h1);
    wr(OFS_SEL, 32'h1);
    wr(OFS_ACK, 32'h1);
    tick(2);
    `CHK(end_n, 1)
    `CHK(ack_n, 1)
    // Interrupt: masked, unmasked, cleared
    rd(OFS_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_MASK, 32'h1);
    tick(2);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STAT, 32'h7);
    tick(2);
    `CHK(irq, 1'b0)
    // Unmapped place reads zero and ignores writes
    wr(8'h3c, 32'hffff_ffff);
    rd(8'h3c, 32'h0);
    rd(OFS_MODE, 32'h3);
    summarize();
  end
endmodule : usb_device_endpoint_control_tb
